// [shared/ssd_pkg.sv]
// Strap capture and default configuration constants
package ssd_pkg;
  // Strap field positions
  localparam int STRAP_WIDTH = 16;
  localparam int BIT_DEBOUNCE = 0;
  localparam int BIT_MGMT_SEL = 3;
  localparam int BIT_ID_LO = 4;
  localparam int BIT_ID_HI = 6;
  localparam int BIT_EEPROM = 7;
  localparam int BIT_HOTSWAP = 9;
  localparam int BIT_PWRSAVE = 11;
  localparam int BIT_TIMEOUT = 12;
  localparam logic [15:0] RSVD_HIGH_MASK = 16'he106;
  localparam logic [15:0] RSVD_LOW_MASK = 16'h0400;
  // Avalon register byte addresses
  localparam logic [3:0] ADDR_STRAPS = 4'h0;
  localparam logic [3:0] ADDR_GLOBAL_CONTROL = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  localparam logic [3:0] ADDR_MODULE = 4'hc;
  localparam int GC_INIT_DONE = 4;
  // Default configuration values
  localparam logic [15:0] DEF_AGE_SECONDS = 16'h012c;
  localparam logic [7:0] DEF_FLOW_FRAMES = 8'h60;
  localparam logic [7:0] DEF_WRED_PCT = 8'h00;
  localparam logic [10:0] DEF_MIN_FRAME = 11'h040;
  localparam logic [10:0] DEF_MAX_FRAME = 11'h5f2;
  localparam logic [8:0] DEF_FE_POOL = 9'h060;
  localparam logic [8:0] DEF_FE_THRESH = 9'h030;
  localparam logic [8:0] DEF_UP_POOL = 9'h180;
  localparam logic [8:0] DEF_UP_THRESH = 9'h0c0;
  localparam logic [3:0] DEF_CPU_PAD = 4'h8;
  localparam logic [3:0] RSVD_DROP_LO = 4'h1;
  localparam logic [3:0] RSVD_DROP_HI = 4'hf;
  // Timing
  localparam int CLK_HZ = 50_000_000;
  localparam int STUCK_SECONDS = 5;
  localparam longint STUCK_CYCLES = longint'(STUCK_SECONDS) * longint'(CLK_HZ);
  localparam int INIT_US = 100;
  localparam int INIT_CYCLES = (INIT_US * (CLK_HZ / 1_000_000));
  localparam int IDLE_CYCLES = 16;
endpackage

// [hw/ssd_strap_init.sv]
// Strap capture, default configuration and switching enable
`timescale 1ns/1ns
module ssd_strap_init
  import ssd_pkg::*;
#(
  parameter int PORTS = 8,
  parameter longint STUCK_COUNT = STUCK_CYCLES,
  parameter int INIT_COUNT = INIT_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic clkEnable,
  input wire logic [15:0] strapPins,
  input wire logic [7:0] fastPortTxEnableStrap,
  input wire logic uplinkTxEnableStrap,
  input wire logic uplinkTxErrorStrap,
  input wire logic [7:0] portActivity,
  input wire logic [7:0] modulePresent,
  input wire logic [7:0] fastPortRxIn,
  input wire logic eepromValid,
  input wire logic eepromHoldSwitch,
  input wire logic fsmBusy,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic unmanagedMode,
  output logic debounceEnable,
  output logic [2:0] serialDeviceId,
  output logic eepromLoadEnable,
  output logic hotswapEnable,
  output logic [9:0] moduleType,
  output logic [7:0] macPowerSave,
  output logic stuckMonitorEnable,
  output logic stuckDetected,
  output logic switchingEnable,
  output logic tablesReady,
  output logic [7:0] fastPortRxEff,
  output logic [7:0] fastPortTxDrive,
  output logic [63:0] defaultConfig
);
  typedef enum {ST_RESET, ST_INIT, ST_WAIT, ST_RUN} ssd_state_t;

  // Pin synchronisers: two flops before any logic
  logic [50:0] syncA;
  logic [50:0] syncB;
  always_ff @(posedge clk) begin
    if (clkEnable) begin
      syncA <= {fsmBusy, modulePresent, fastPortRxIn, portActivity, uplinkTxErrorStrap,
                uplinkTxEnableStrap, fastPortTxEnableStrap, strapPins};
      syncB <= syncA;
    end
  end
  logic [15:0] sStrap;
  logic [9:0] sModPins;
  logic [7:0] sAct;
  logic [7:0] sRx;
  logic [7:0] sPresent;
  logic sBusy;
  assign sStrap = syncB[15:0];
  assign sModPins = syncB[25:16];
  assign sAct = syncB[33:26];
  assign sRx = syncB[41:34];
  assign sPresent = syncB[49:42];
  assign sBusy = syncB[50];

  // Strap latch: tracks pins during reset, frozen after release
  logic [15:0] strapReg;
  logic [9:0] modReg;
  logic [15:0] next_strapReg;
  logic [9:0] next_modReg;
  always_comb begin
    next_strapReg = strapReg;
    next_modReg = modReg;
    if (reset) begin
      next_strapReg = sStrap;
      next_modReg = sModPins;
    end
  end
  always_ff @(posedge clk) begin
    if (clkEnable) begin
      strapReg <= next_strapReg;
      modReg <= next_modReg;
    end
  end

  // Decoded strap options, registered
  always_ff @(posedge clk) begin
    if (reset) begin
      unmanagedMode <= 1'b1;
      debounceEnable <= 1'b1;
      serialDeviceId <= 3'h0;
      eepromLoadEnable <= 1'b0;
      hotswapEnable <= 1'b0;
      moduleType <= 10'h000;
      stuckMonitorEnable <= 1'b0;
    end else if (clkEnable) begin
      unmanagedMode <= strapReg[BIT_MGMT_SEL];
      debounceEnable <= strapReg[BIT_DEBOUNCE];
      serialDeviceId <= strapReg[BIT_ID_HI:BIT_ID_LO];
      // Active-low select; ignored unless unmanaged
      eepromLoadEnable <= strapReg[BIT_MGMT_SEL] & ~strapReg[BIT_EEPROM];
      hotswapEnable <= strapReg[BIT_HOTSWAP];
      moduleType <= strapReg[BIT_HOTSWAP] ? modReg : 10'h000;
      stuckMonitorEnable <= strapReg[BIT_TIMEOUT];
    end
  end

  // Per-port inactivity counters drive power saving
  logic [4:0] idleCnt [PORTS];
  logic [4:0] next_idleCnt [PORTS];
  logic [7:0] next_macPowerSave;
  always_comb begin
    next_macPowerSave = macPowerSave;
    for (int i = 0; i < PORTS; i++) begin
      next_idleCnt[i] = idleCnt[i];
      if (sAct[i]) begin
        next_idleCnt[i] = 5'h00;
        next_macPowerSave[i] = 1'b0;
      end else if (idleCnt[i] != 5'(IDLE_CYCLES)) begin
        next_idleCnt[i] = idleCnt[i] + 5'h01;
      end else begin
        next_macPowerSave[i] = strapReg[BIT_PWRSAVE];
      end
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      macPowerSave <= 8'h00;
      for (int i = 0; i < PORTS; i++) idleCnt[i] <= 5'h00;
    end else if (clkEnable) begin
      macPowerSave <= next_macPowerSave;
      for (int i = 0; i < PORTS; i++) idleCnt[i] <= next_idleCnt[i];
    end
  end

  // Stuck monitor; counts busy time, sticky until reset
  logic [31:0] stuckCnt;
  logic [31:0] next_stuckCnt;
  logic next_stuckDetected;
  always_comb begin
    next_stuckCnt = stuckCnt;
    next_stuckDetected = stuckDetected;
    if (!stuckMonitorEnable || !sBusy) begin
      next_stuckCnt = 32'h0;
    end else if (stuckCnt >= 32'(STUCK_COUNT)) begin
      next_stuckDetected = 1'b1;
    end else begin
      next_stuckCnt = stuckCnt + 32'h1;
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      stuckCnt <= 32'h0;
      stuckDetected <= 1'b0;
    end else if (clkEnable) begin
      stuckCnt <= next_stuckCnt;
      stuckDetected <= next_stuckDetected;
    end
  end

  // Init sequencer: table init, then wait for go unless unmanaged
  ssd_state_t state;
  ssd_state_t next_state;
  logic [15:0] initCnt;
  logic [15:0] next_initCnt;
  logic initDone;
  logic next_initDone;
  logic next_switchingEnable;
  always_comb begin
    next_state = state;
    next_initCnt = initCnt;
    next_initDone = initDone;
    next_switchingEnable = 1'b0;
    case (state)
      ST_RESET: next_state = ST_INIT;
      ST_INIT: begin
        if (initCnt >= 16'(INIT_COUNT)) begin
          next_state = unmanagedMode ? ST_RUN : ST_WAIT;
        end else begin
          next_initCnt = initCnt + 16'h1;
        end
      end
      ST_WAIT: begin
        if (initDone) next_state = ST_RUN;
      end
      ST_RUN: next_switchingEnable = !(unmanagedMode && eepromLoadEnable && eepromHoldSwitch);
      default: next_state = ST_RESET;
    endcase
    // Unmanaged starts at once; EEPROM may briefly hold it
    if (state != ST_RESET && unmanagedMode) begin
      next_switchingEnable = !(eepromLoadEnable && eepromHoldSwitch);
    end
    if (avs_write && !avs_waitrequest && avs_address == ADDR_GLOBAL_CONTROL) begin
      next_initDone = avs_writedata[GC_INIT_DONE];
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      state <= ST_RESET;
      initCnt <= 16'h0;
      initDone <= 1'b0;
      switchingEnable <= 1'b0;
      tablesReady <= 1'b0;
    end else if (clkEnable) begin
      state <= next_state;
      initCnt <= next_initCnt;
      initDone <= next_initDone;
      switchingEnable <= next_switchingEnable;
      tablesReady <= (state == ST_WAIT) || (state == ST_RUN);
    end
  end

  // Hotswap: empty ports read high receive, transmit driven
  always_ff @(posedge clk) begin
    if (reset) begin
      fastPortRxEff <= 8'hff;
      fastPortTxDrive <= 8'hff;
    end else if (clkEnable) begin
      for (int i = 0; i < PORTS; i++) begin
        fastPortRxEff[i] <= (hotswapEnable && !sPresent[i]) ? 1'b1 : sRx[i];
        fastPortTxDrive[i] <= 1'b1;
      end
    end
  end

  // Default configuration vector, mode dependent fields
  always_ff @(posedge clk) begin
    if (reset) begin
      defaultConfig <= 64'h0;
    end else if (clkEnable) begin
      defaultConfig[15:0] <= DEF_AGE_SECONDS;
      defaultConfig[23:16] <= DEF_FLOW_FRAMES;
      defaultConfig[31:24] <= DEF_WRED_PCT;
      defaultConfig[40:32] <= DEF_FE_POOL;
      defaultConfig[49:41] <= unmanagedMode ? DEF_UP_POOL : DEF_FE_POOL;
      defaultConfig[53:50] <= unmanagedMode ? 4'h0 : DEF_CPU_PAD;
      defaultConfig[54] <= !unmanagedMode;
      defaultConfig[55] <= 1'b1;
      defaultConfig[56] <= 1'b1;
      defaultConfig[57] <= 1'b1;
      defaultConfig[58] <= 1'b0;
      defaultConfig[63:59] <= 5'h00;
    end
  end

  // Avalon slave: one wait state on every access
  logic accept;
  logic next_waitrequest;
  logic [31:0] next_readdata;
  assign accept = (avs_read || avs_write) && avs_waitrequest;
  always_comb begin
    next_waitrequest = 1'b1;
    next_readdata = avs_readdata;
    if (accept && !(avs_read && avs_write)) begin
      next_waitrequest = 1'b0;
      case (avs_address)
        ADDR_STRAPS: next_readdata = {16'h0, strapReg};
        ADDR_GLOBAL_CONTROL: next_readdata = {27'h0, initDone, 4'h0};
        ADDR_STATUS: next_readdata = {26'h0, stuckDetected, tablesReady, switchingEnable,
                                      eepromLoadEnable, hotswapEnable, unmanagedMode};
        ADDR_MODULE: next_readdata = {14'h0, macPowerSave, moduleType};
        default: next_readdata = 32'h0;
      endcase
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0;
    end else if (clkEnable) begin
      avs_waitrequest <= next_waitrequest;
      avs_readdata <= next_readdata;
    end
  end

  // Checks
  property p_strap_frozen;
    @(posedge clk) disable iff (reset) clkEnable && !reset |=> $stable(strapReg);
  endproperty
  a_strap_frozen: assert property (p_strap_frozen) else $error("strap changed");
  property p_mgmt;
    @(posedge clk) disable iff (reset) clkEnable && !reset |=> unmanagedMode == $past(strapReg[3]);
  endproperty
  a_mgmt: assert property (p_mgmt) else $error("mode wrong");
  property p_debounce;
    @(posedge clk) disable iff (reset) clkEnable && !reset |=> debounceEnable == $past(strapReg[0]);
  endproperty
  a_debounce: assert property (p_debounce) else $error("debounce wrong");
  property p_id;
    @(posedge clk) disable iff (reset) clkEnable && !reset |=> serialDeviceId == $past(strapReg[6:4]);
  endproperty
  a_id: assert property (p_id) else $error("id wrong");
  property p_eeprom;
    @(posedge clk) disable iff (reset) eepromLoadEnable |-> unmanagedMode;
  endproperty
  a_eeprom: assert property (p_eeprom) else $error("eeprom in managed");
  property p_hotswap;
    @(posedge clk) disable iff (reset) !hotswapEnable |-> moduleType == 10'h000;
  endproperty
  a_hotswap: assert property (p_hotswap) else $error("module type leak");
  property p_save;
    @(posedge clk) disable iff (reset) clkEnable && !reset && sAct[0] |=> !macPowerSave[0];
  endproperty
  a_save: assert property (p_save) else $error("save while active");
  property p_stuck;
    @(posedge clk) disable iff (reset) stuckDetected |-> stuckMonitorEnable || $past(stuckDetected);
  endproperty
  a_stuck: assert property (p_stuck) else $error("stuck without monitor");
  sequence s_waiting;
    state == ST_WAIT && !initDone;
  endsequence
  property p_hold;
    @(posedge clk) disable iff (reset) s_waiting |=> !switchingEnable;
  endproperty
  a_hold: assert property (p_hold) else $error("switching before init");
  property p_flow;
    @(posedge clk) disable iff (reset) clkEnable && !reset |=> defaultConfig[23:16] == DEF_FLOW_FRAMES;
  endproperty
  a_flow: assert property (p_flow) else $error("flow default");
endmodule

// [test/ssd_board_model.sv]
// Board strap resistors that share the test-output and transmit-enable pins
`timescale 1ns/1ns
module ssd_board_model
  import ssd_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [15:0] strapCfg,
  input wire logic [9:0] portCfg,
  output logic [15:0] strapPins,
  output logic [7:0] fastPortTxEnableStrap,
  output logic uplinkTxEnableStrap,
  output logic uplinkTxErrorStrap
);
  logic [25:0] pinLevel = 26'h0;
  // Resistors set levels in reset; afterwards every pin inverts each cycle, so the strap levels show on alternate cycles
  always @(posedge clk) begin
    if (reset) begin
      pinLevel <= {portCfg, (strapCfg & ~RSVD_LOW_MASK) | RSVD_HIGH_MASK};
    end else begin
      pinLevel <= ~pinLevel;
    end
  end
  assign {uplinkTxErrorStrap, uplinkTxEnableStrap, fastPortTxEnableStrap, strapPins} = pinLevel;
endmodule

// [test/tb_top.sv]
// Self-checking bench for strap capture, defaults and switching enable
`timescale 1ns/1ns
module tb_top
  import ssd_pkg::*;
;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [15:0] strapCfg = 16'hffff;
  logic [9:0] portCfg = 10'h0;
  logic [7:0] portActivity = 8'hff;
  logic [7:0] modulePresent = 8'hff;
  logic [7:0] fastPortRxIn = 8'h0;
  logic fsmBusy = 1'b0;
  logic clkEnable = 1'b1;
  logic eepromHoldSwitch = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic unmanagedMode, debounceEnable, eepromLoadEnable, hotswapEnable;
  logic stuckMonitorEnable, stuckDetected, switchingEnable, tablesReady;
  logic [2:0] serialDeviceId;
  logic [9:0] moduleType;
  logic [7:0] macPowerSave, fastPortRxEff, fastPortTxDrive;
  logic [63:0] defaultConfig;
  logic [15:0] strapPins;
  logic [7:0] fastPortTxEnableStrap;
  logic uplinkTxEnableStrap, uplinkTxErrorStrap;
  logic [31:0] seed = 32'hddcaf972;
  int bad_count = 0;
  int cmp_count = 0;

  always #10 clk = ~clk;

  ssd_board_model u_board (.clk(clk), .reset(reset), .strapCfg(strapCfg), .portCfg(portCfg),
    .strapPins(strapPins), .fastPortTxEnableStrap(fastPortTxEnableStrap),
    .uplinkTxEnableStrap(uplinkTxEnableStrap), .uplinkTxErrorStrap(uplinkTxErrorStrap));

  // Short counts keep the init and stuck waits to a few dozen cycles
  ssd_strap_init #(.STUCK_COUNT(20), .INIT_COUNT(8)) u_dut (.clk(clk),
    .reset(reset), .clkEnable(clkEnable), .strapPins(strapPins),
    .fastPortTxEnableStrap(fastPortTxEnableStrap), .uplinkTxEnableStrap(uplinkTxEnableStrap),
    .uplinkTxErrorStrap(uplinkTxErrorStrap), .portActivity(portActivity),
    .modulePresent(modulePresent), .fastPortRxIn(fastPortRxIn), .eepromValid(1'b0),
    .eepromHoldSwitch(eepromHoldSwitch), .fsmBusy(fsmBusy), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .unmanagedMode(unmanagedMode), .debounceEnable(debounceEnable),
    .serialDeviceId(serialDeviceId), .eepromLoadEnable(eepromLoadEnable),
    .hotswapEnable(hotswapEnable), .moduleType(moduleType), .macPowerSave(macPowerSave),
    .stuckMonitorEnable(stuckMonitorEnable), .stuckDetected(stuckDetected),
    .switchingEnable(switchingEnable), .tablesReady(tablesReady),
    .fastPortRxEff(fastPortRxEff), .fastPortTxDrive(fastPortTxDrive),
    .defaultConfig(defaultConfig));

  // Fixed-seed xorshift so every run repeats
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Default configuration word; only the CPU-port fields depend on mode
  function automatic logic [58:0] cfgExp(input logic unm);
    return {1'b0, 3'b111, ~unm, unm ? 4'h0 : DEF_CPU_PAD, unm ? DEF_UP_POOL : DEF_FE_POOL,
      DEF_FE_POOL, DEF_WRED_PCT, DEF_FLOW_FRAMES, DEF_AGE_SECONDS};
  endfunction

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One Avalon transfer; request held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= wd;
    avs_read <= ~wr;
    avs_write <= wr;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    chk("waitrequest", 1'b0, avs_waitrequest);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Watchdog sized well above eight passes of about 130 cycles
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    complete_run();
  end

  initial begin
    logic [31:0] r, rd;
    logic [15:0] se;
    logic [7:0] ev;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    for (int it = 0; it < 8; it++) begin
      r = rnd();
      se = (it == 0) ? 16'hffff : (it == 1) ? 16'h0000 : r[15:0];
      se[3] = ~it[0];
      se = (se & ~RSVD_LOW_MASK) | RSVD_HIGH_MASK;
      strapCfg <= se;
      portCfg <= r[25:16];
      // Longer re-reset so fresh levels clear the synchroniser
      reset <= 1'b1;
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      repeat (3) @(posedge clk);
      chk("unmanaged", se[BIT_MGMT_SEL], unmanagedMode);
      chk("debounce", se[BIT_DEBOUNCE], debounceEnable);
      chk("devId", se[BIT_ID_HI:BIT_ID_LO], serialDeviceId);
      chk("eeprom", se[3] & ~se[7], eepromLoadEnable);
      chk("hotswap", se[9], hotswapEnable);
      chk("modType", se[9] ? r[25:16] : 10'h0, moduleType);
      chk("stuckEn", se[12], stuckMonitorEnable);
      bus(1'b0, ADDR_STRAPS, 32'h0, rd);
      chk("strapReg", se, rd);
      bus(1'b0, 4'h2, 32'h0, rd);
      chk("unmapped", 32'h0, rd);
      // Host waits for table init before touching control
      for (int k = 0; k < 40 && tablesReady !== 1'b1; k++) @(posedge clk);
      chk("tablesReady", 1'b1, tablesReady);
      if (se[3]) begin
        chk("switchUnm", 1'b1, switchingEnable);
        // EEPROM hold only bites when the EEPROM select is active
        eepromHoldSwitch <= 1'b1;
        repeat (2) @(posedge clk);
        chk("eepromHold", se[BIT_EEPROM], switchingEnable);
        eepromHoldSwitch <= 1'b0;
        repeat (2) @(posedge clk);
        chk("eepromFree", 1'b1, switchingEnable);
      end else begin
        chk("switchHeld", 1'b0, switchingEnable);
        bus(1'b1, ADDR_GLOBAL_CONTROL, 32'h10, rd);
        repeat (3) @(posedge clk);
        chk("switchGo", 1'b1, switchingEnable);
      end
      bus(1'b0, ADDR_STATUS, 32'h0, rd);
      chk("status", {3'b011, se[3] & ~se[7], se[9], se[3]}, rd[5:0]);
      chk("defaults", cfgExp(se[3]), defaultConfig[58:0]);
      r = rnd();
      modulePresent <= r[7:0];
      fastPortRxIn <= r[15:8];
      portActivity <= r[23:16];
      repeat (25) @(posedge clk);
      ev = se[9] ? (r[15:8] | ~r[7:0]) : r[15:8];
      chk("rxEff", ev, fastPortRxEff);
      chk("txDrive", 8'hff, fastPortTxDrive);
      ev = se[11] ? ~r[23:16] : 8'h0;
      chk("pwrSave", ev, macPowerSave);
      portActivity <= 8'hff;
      fsmBusy <= 1'b1;
      repeat (8) @(posedge clk);
      chk("pwrWake", 8'h0, macPowerSave);
      repeat (32) @(posedge clk);
      chk("stuck", se[12], stuckDetected);
      fsmBusy <= 1'b0;
      // Write to an unmapped address, then confirm straps never followed the toggling pins
      bus(1'b1, 4'h6, 32'hffff, rd);
      bus(1'b0, ADDR_STRAPS, 32'h0, rd);
      chk("strapHold", se, rd);
      chk("idHold", se[BIT_ID_HI:BIT_ID_LO], serialDeviceId);
      // Frozen clock enable: idle ports must not drift into power saving
      clkEnable <= 1'b0;
      portActivity <= 8'h00;
      repeat (25) @(posedge clk);
      chk("freeze", 8'h0, macPowerSave);
      clkEnable <= 1'b1;
      portActivity <= 8'hff;
    end
    complete_run();
  end
endmodule
